// *** rtl/ssi_pkg.sv ***
// Package with the register map, flag layout and event carrier type.
package ssi_pkg;

  // ****************************************************************
  // Register bus geometry
  // ****************************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NUM_SRC = 12;

  // Byte offsets of the four registers, each one aligned word.
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 8'h44;
  localparam logic [ADDR_W-1:0] OFS_IRQ_DISABLE = 8'h48;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h4C;

  // ****************************************************************
  // Flag positions; bits 0 to 11 shared by status, enable, disable and mask, bits 16 and 17 status only
  // ****************************************************************
  localparam int BIT_TX_READY = 0;
  localparam int BIT_TX_EMPTY = 1;
  localparam int BIT_END_OF_TX = 2;
  localparam int BIT_TX_BUFFER_EMPTY = 3;
  localparam int BIT_RX_READY = 4;
  localparam int BIT_RX_OVERRUN = 5;
  localparam int BIT_END_OF_RX = 6;
  localparam int BIT_RX_BUFFER_FULL = 7;
  localparam int BIT_COMPARE_ZERO = 8;
  localparam int BIT_COMPARE_ONE = 9;
  localparam int BIT_TX_SYNC = 10;
  localparam int BIT_RX_SYNC = 11;
  localparam int BIT_TX_ENABLED = 16;
  localparam int BIT_RX_ENABLED = 17;

  // Flags that latch an event; the others follow a level each cycle.
  localparam logic [NUM_SRC-1:0] STICKY_FLAGS = 12'hF74;

  // Reset values.
  localparam logic [NUM_SRC-1:0] MASK_RESET = 12'h000;
  localparam logic [NUM_SRC-1:0] FLAGS_RESET = 12'h000;
  localparam logic [DATA_W-1:0] RD_DATA_RESET = 32'h0000_0000;

  // ****************************************************************
  // Signals from the serial datapath and the peripheral DMA counters
  // ****************************************************************
  typedef struct packed {
    logic tx_holding_empty;
    logic tx_shift_idle;
    logic tx_dma_count_zero;
    logic tx_dma_next_count_zero;
    logic rx_dma_count_zero;
    logic rx_dma_next_count_zero;
    logic rx_holding_load;
    logic rx_holding_read;
    logic tx_count_write;
    logic rx_count_write;
    logic compare_zero_hit;
    logic compare_one_hit;
    logic tx_sync_event;
    logic rx_sync_event;
    logic tx_enabled;
    logic rx_enabled;
  } ssi_events_t;

endpackage

// *** rtl/ssi_flag_cell.sv ***
// One sticky status flag: set has priority over clear.
`timescale 1ns/1ps

module ssi_flag_cell (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_set,
  input wire logic i_clear,
  output logic o_flag
);

  // ****************************************************************
  // Flag storage
  // ****************************************************************
  logic flag_q;
  logic flag_d;

  // An event in the same cycle as its clear must not be lost.
  assign flag_d = i_set ? 1'b1 : (i_clear ? 1'b0 : flag_q);

  // Synchronous reset keeps the flag defined from the first edge.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign o_flag = flag_q;

endmodule

// *** rtl/ssi_status_irq.sv ***
// Status flags, interrupt mask and interrupt line of the serial block.
// ****************************************************************
// Overview of operation
// - Tx buffer empty when both tx counters zero.
// - Rx buffer full when both rx counters zero.
// - Rx ready set on load, cleared when read.
// - Overrun when loading over an unread word.
// - End of rx on zero, cleared by write.
// - Compare zero latched, cleared by status read.
// - Compare one latched, cleared by status read.
// - Tx sync latched until next status read.
// - Rx sync latched until next status read.
// - Status shows transmitter enabled state.
// - Status shows receiver enabled state.
// - Enable register writes ones into mask.
// - Disable register clears mask where one written.
// - Mask register reads back enabled sources.
// - Twelve sources at bits zero to eleven.
// - Tx ready while tx holding register empty.
// - Tx empty after last word shifted out.
// - End of tx on zero, cleared by write.
// ****************************************************************
`timescale 1ns/1ps

module ssi_status_irq (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic [ssi_pkg::ADDR_W-1:0] i_addr,
  input wire logic [ssi_pkg::DATA_W-1:0] i_wr_data,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire ssi_pkg::ssi_events_t i_events,
  output logic [ssi_pkg::DATA_W-1:0] o_rd_data,
  output logic o_irq
);

  // ****************************************************************
  // Address decode
  // ****************************************************************
  wire sel_status;
  wire sel_enable;
  wire sel_disable;
  wire sel_mask;
  wire status_rd;
  wire enable_wr;
  wire disable_wr;

  // Each register answers only at its own aligned word.
  assign sel_status = (i_addr == ssi_pkg::OFS_STATUS);
  assign sel_enable = (i_addr == ssi_pkg::OFS_IRQ_ENABLE);
  assign sel_disable = (i_addr == ssi_pkg::OFS_IRQ_DISABLE);
  assign sel_mask = (i_addr == ssi_pkg::OFS_IRQ_MASK);
  assign status_rd = i_rd_en && sel_status;
  assign enable_wr = i_wr_en && sel_enable;
  assign disable_wr = i_wr_en && sel_disable;

  // ****************************************************************
  // Counter zero edge detection
  // ****************************************************************
  logic tx_zero_q;
  logic rx_zero_q;
  wire tx_reach_zero;
  wire rx_reach_zero;

  // Remember the counter state so arrival at zero is a single event.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      tx_zero_q <= 1'b0;
      rx_zero_q <= 1'b0;
    end else begin
      tx_zero_q <= i_events.tx_dma_count_zero;
      rx_zero_q <= i_events.rx_dma_count_zero;
    end
  end

  // A write that leaves a counter at zero does not retrigger the flag.
  assign tx_reach_zero = i_events.tx_dma_count_zero && !tx_zero_q;
  assign rx_reach_zero = i_events.rx_dma_count_zero && !rx_zero_q;

  // ****************************************************************
  // Set, clear and level vectors in flag order
  // ****************************************************************
  logic [ssi_pkg::NUM_SRC-1:0] set_v;
  logic [ssi_pkg::NUM_SRC-1:0] clr_v;
  logic [ssi_pkg::NUM_SRC-1:0] lvl_v;
  wire [ssi_pkg::NUM_SRC-1:0] flags_w;

  // Level-driven flags follow the datapath every cycle.
  always_comb begin
    lvl_v = ssi_pkg::FLAGS_RESET;
    lvl_v[ssi_pkg::BIT_TX_READY] = i_events.tx_holding_empty;
    lvl_v[ssi_pkg::BIT_TX_EMPTY] = i_events.tx_holding_empty &&
      i_events.tx_shift_idle;
    lvl_v[ssi_pkg::BIT_TX_BUFFER_EMPTY] = i_events.tx_dma_count_zero &&
      i_events.tx_dma_next_count_zero;
    lvl_v[ssi_pkg::BIT_RX_BUFFER_FULL] = i_events.rx_dma_count_zero &&
      i_events.rx_dma_next_count_zero;
  end

  // Events that latch a flag.
  always_comb begin
    set_v = ssi_pkg::FLAGS_RESET;
    set_v[ssi_pkg::BIT_END_OF_TX] = tx_reach_zero;
    set_v[ssi_pkg::BIT_RX_READY] = i_events.rx_holding_load;
    set_v[ssi_pkg::BIT_RX_OVERRUN] = i_events.rx_holding_load &&
      flags_w[ssi_pkg::BIT_RX_READY];
    set_v[ssi_pkg::BIT_END_OF_RX] = rx_reach_zero;
    set_v[ssi_pkg::BIT_COMPARE_ZERO] = i_events.compare_zero_hit;
    set_v[ssi_pkg::BIT_COMPARE_ONE] = i_events.compare_one_hit;
    set_v[ssi_pkg::BIT_TX_SYNC] = i_events.tx_sync_event;
    set_v[ssi_pkg::BIT_RX_SYNC] = i_events.rx_sync_event;
  end

  // Clears: holding reads for rx ready, status reads for the other event flags, counter writes for DMA ends.
  always_comb begin
    clr_v = ssi_pkg::FLAGS_RESET;
    clr_v[ssi_pkg::BIT_END_OF_TX] = i_events.tx_count_write;
    clr_v[ssi_pkg::BIT_RX_READY] = i_events.rx_holding_read;
    clr_v[ssi_pkg::BIT_RX_OVERRUN] = status_rd;
    clr_v[ssi_pkg::BIT_END_OF_RX] = i_events.rx_count_write;
    clr_v[ssi_pkg::BIT_COMPARE_ZERO] = status_rd;
    clr_v[ssi_pkg::BIT_COMPARE_ONE] = status_rd;
    clr_v[ssi_pkg::BIT_TX_SYNC] = status_rd;
    clr_v[ssi_pkg::BIT_RX_SYNC] = status_rd;
  end

  // ****************************************************************
  // Flag storage, one cell per source
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < ssi_pkg::NUM_SRC; gi = gi + 1) begin : g_flag
      if (ssi_pkg::STICKY_FLAGS[gi]) begin : g_sticky
        ssi_flag_cell u_cell (
          .i_clock(i_clock),
          .i_rst_n(i_rst_n),
          .i_set(set_v[gi]),
          .i_clear(clr_v[gi]),
          .o_flag(flags_w[gi])
        );
      end else begin : g_level
        logic lvl_q;
        // Registered so the read value and the interrupt line agree.
        always_ff @(posedge i_clock) begin
          if (!i_rst_n) begin
            lvl_q <= 1'b0;
          end else begin
            lvl_q <= lvl_v[gi];
          end
        end
        assign flags_w[gi] = lvl_q;
      end
    end
  endgenerate

  // ****************************************************************
  // Enable state mirror
  // ****************************************************************
  logic tx_en_q;
  logic rx_en_q;

  // The datapath owns the enables; this block only reports them.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      tx_en_q <= 1'b0;
      rx_en_q <= 1'b0;
    end else begin
      tx_en_q <= i_events.tx_enabled;
      rx_en_q <= i_events.rx_enabled;
    end
  end

  // ****************************************************************
  // Interrupt mask
  // ****************************************************************
  logic [ssi_pkg::NUM_SRC-1:0] mask_q;
  logic [ssi_pkg::NUM_SRC-1:0] mask_d;
  wire [ssi_pkg::NUM_SRC-1:0] wr_src;

  assign wr_src = i_wr_data[ssi_pkg::NUM_SRC-1:0];

  // Set and clear by ones let drivers touch one source atomically.
  always_comb begin
    mask_d = mask_q;
    if (enable_wr) begin
      mask_d = mask_q | wr_src;
    end else if (disable_wr) begin
      mask_d = mask_q & ~wr_src;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      mask_q <= ssi_pkg::MASK_RESET;
    end else begin
      mask_q <= mask_d;
    end
  end

  // ****************************************************************
  // Read data and interrupt output
  // ****************************************************************
  logic [ssi_pkg::DATA_W-1:0] status_word;
  logic [ssi_pkg::DATA_W-1:0] mask_word;
  wire [ssi_pkg::DATA_W-1:0] rd_mux;
  logic [ssi_pkg::DATA_W-1:0] rd_data_q;
  logic irq_q;

  // Unused bits read as zero.
  always_comb begin
    status_word = ssi_pkg::RD_DATA_RESET;
    status_word[ssi_pkg::NUM_SRC-1:0] = flags_w;
    status_word[ssi_pkg::BIT_TX_ENABLED] = tx_en_q;
    status_word[ssi_pkg::BIT_RX_ENABLED] = rx_en_q;
    mask_word = ssi_pkg::RD_DATA_RESET;
    mask_word[ssi_pkg::NUM_SRC-1:0] = mask_q;
  end

  // Write-only and unmapped words read as zero.
  assign rd_mux = sel_status ? status_word :
                  (sel_mask ? mask_word : ssi_pkg::RD_DATA_RESET);

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      rd_data_q <= ssi_pkg::RD_DATA_RESET;
      irq_q <= 1'b0;
    end else begin
      rd_data_q <= i_rd_en ? rd_mux : ssi_pkg::RD_DATA_RESET;
      irq_q <= |(flags_w & mask_q);
    end
  end

  assign o_rd_data = rd_data_q;
  assign o_irq = irq_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  logic chk_run_q;

  // Checks other than a_mask_reset start one edge after reset ends, because an attempt
  // begun on the releasing edge would sample inputs that the reset flops ignored.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      chk_run_q <= 1'b0;
    end else begin
      chk_run_q <= 1'b1;
    end
  end

  property p_tx_buf_empty;
    @(posedge i_clock) disable iff (!i_rst_n || !chk_run_q)
      ##1 flags_w[ssi_pkg::BIT_TX_BUFFER_EMPTY] ==
        $past(i_events.tx_dma_count_zero && i_events.tx_dma_next_count_zero);
  endproperty
  a_tx_buf_empty: assert property (p_tx_buf_empty)
    else $error("tx buffer empty flag does not follow counters");

  property p_rx_buf_full;
    @(posedge i_clock) disable iff (!i_rst_n || !chk_run_q)
      (i_events.rx_dma_count_zero && i_events.rx_dma_next_count_zero)
        |=> flags_w[ssi_pkg::BIT_RX_BUFFER_FULL];
  endproperty
  a_rx_buf_full: assert property (p_rx_buf_full)
    else $error("rx buffer full flag missing with counters at zero");

  property p_rx_ready;
    @(posedge i_clock) disable iff (!i_rst_n || !chk_run_q)
      i_events.rx_holding_load |=> flags_w[ssi_pkg::BIT_RX_READY];
  endproperty
  a_rx_ready: assert property (p_rx_ready)
    else $error("rx ready not set after holding load");

  property p_overrun;
    @(posedge i_clock) disable iff (!i_rst_n || !chk_run_q)
      (i_events.rx_holding_load && flags_w[ssi_pkg::BIT_RX_READY])
        |=> flags_w[ssi_pkg::BIT_RX_OVERRUN];
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("overrun not set on load over unread word");

  property p_end_rx_clear;
    @(posedge i_clock) disable iff (!i_rst_n || !chk_run_q)
      (i_events.rx_count_write && !rx_reach_zero)
        |=> !flags_w[ssi_pkg::BIT_END_OF_RX];
  endproperty
  a_end_rx_clear: assert property (p_end_rx_clear)
    else $error("end of rx not cleared by counter write");

  property p_cp0_hold;
    @(posedge i_clock) disable iff (!i_rst_n || !chk_run_q)
      i_events.compare_zero_hit ##1 !status_rd [*2]
        |-> flags_w[ssi_pkg::BIT_COMPARE_ZERO];
  endproperty
  a_cp0_hold: assert property (p_cp0_hold)
    else $error("compare zero flag not held until status read");

  property p_cp1_clear;
    @(posedge i_clock) disable iff (!i_rst_n || !chk_run_q)
      (status_rd && !i_events.compare_one_hit)
        |=> !flags_w[ssi_pkg::BIT_COMPARE_ONE];
  endproperty
  a_cp1_clear: assert property (p_cp1_clear)
    else $error("compare one flag survived a status read");

  property p_tx_sync;
    @(posedge i_clock) disable iff (!i_rst_n || !chk_run_q)
      i_events.tx_sync_event |=> flags_w[ssi_pkg::BIT_TX_SYNC];
  endproperty
  a_tx_sync: assert property (p_tx_sync)
    else $error("tx sync flag not set on event");

  property p_rx_sync_keep;
    @(posedge i_clock) disable iff (!i_rst_n || !chk_run_q)
      (flags_w[ssi_pkg::BIT_RX_SYNC] && !status_rd)
        |=> flags_w[ssi_pkg::BIT_RX_SYNC];
  endproperty
  a_rx_sync_keep: assert property (p_rx_sync_keep)
    else $error("rx sync flag dropped without status read");

  property p_enable_write;
    @(posedge i_clock) disable iff (!i_rst_n || !chk_run_q)
      enable_wr |=> ((mask_q & $past(wr_src)) == $past(wr_src));
  endproperty
  a_enable_write: assert property (p_enable_write)
    else $error("enable write did not set mask bits");

  property p_disable_write;
    @(posedge i_clock) disable iff (!i_rst_n || !chk_run_q)
      disable_wr |=> ((mask_q & $past(wr_src)) == 12'h000);
  endproperty
  a_disable_write: assert property (p_disable_write)
    else $error("disable write did not clear mask bits");

  property p_mask_read;
    @(posedge i_clock) disable iff (!i_rst_n || !chk_run_q)
      (i_rd_en && sel_mask) |=> (o_rd_data == {20'h00000, $past(mask_q)});
  endproperty
  a_mask_read: assert property (p_mask_read)
    else $error("mask read data wrong");

  property p_irq;
    @(posedge i_clock) disable iff (!i_rst_n || !chk_run_q)
      ##1 o_irq == $past(|(flags_w & mask_q));
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt line disagrees with flags and mask");

  property p_mask_reset;
    @(posedge i_clock)
      !i_rst_n |=> (mask_q == ssi_pkg::MASK_RESET);
  endproperty
  a_mask_reset: assert property (p_mask_reset)
    else $error("mask not clear after reset");

endmodule

// *** verification/ssi_datapath_model.sv ***
// Behavioural model of the serial datapath and its DMA counters.
`timescale 1ns/1ps

module ssi_datapath_model (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire ssi_pkg::ssi_events_t i_drive,
  input wire logic i_step,
  input wire logic [1:0] i_load,
  input wire logic [7:0] i_counts,
  output ssi_pkg::ssi_events_t o_events
);
  // ****************************************************************
  // DMA counters
  // ****************************************************************
  logic [1:0] tx_cnt_q, tx_nxt_q, rx_cnt_q, rx_nxt_q;
  logic tx_wr_q, rx_wr_q;

  // Counts down; an empty current counter takes over the next one.
  function automatic logic [3:0] advance(input logic [1:0] c,
      input logic [1:0] n);
    if (c != 2'h0) return {c - 2'h1, n};
    return {n, 2'h0};
  endfunction

  // Small counters keep the zero crossings frequent under random steps.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      {tx_cnt_q, tx_nxt_q, rx_cnt_q, rx_nxt_q} <= 8'h00;
      {tx_wr_q, rx_wr_q} <= 2'h0;
    end else begin
      {tx_wr_q, rx_wr_q} <= {i_load[0], i_load[1]};
      if (i_load[0]) {tx_cnt_q, tx_nxt_q} <= i_counts[3:0];
      else if (i_step) {tx_cnt_q, tx_nxt_q} <= advance(tx_cnt_q, tx_nxt_q);
      if (i_load[1]) {rx_cnt_q, rx_nxt_q} <= i_counts[7:4];
      else if (i_step) {rx_cnt_q, rx_nxt_q} <= advance(rx_cnt_q, rx_nxt_q);
    end
  end

  // Pulses and levels pass through; counter views come from the model.
  always_comb begin
    o_events = i_drive;
    o_events.tx_dma_count_zero = (tx_cnt_q == 2'h0);
    o_events.tx_dma_next_count_zero = (tx_nxt_q == 2'h0);
    o_events.rx_dma_count_zero = (rx_cnt_q == 2'h0);
    o_events.rx_dma_next_count_zero = (rx_nxt_q == 2'h0);
    o_events.tx_count_write = tx_wr_q;
    o_events.rx_count_write = rx_wr_q;
  end
endmodule

// *** verification/sync_serial_status_irq_tb_top.sv ***
// Random self-checking testbench of the status and interrupt block.
`timescale 1ns/1ps

module sync_serial_status_irq_tb_top;
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wr_data = 32'h0000_0000;
  logic i_wr_en = 1'b0;
  logic i_rd_en = 1'b0;
  ssi_pkg::ssi_events_t drive = 16'h0000;
  logic step = 1'b0;
  logic [1:0] load = 2'h0;
  logic [7:0] counts = 8'h00;
  ssi_pkg::ssi_events_t ev;
  logic [31:0] o_rd_data;
  logic o_irq;
  integer seed = 32'h727AC8C0;
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;
  logic armed = 1'b0;
  logic [7:0] addrs [8] = '{ssi_pkg::OFS_STATUS, ssi_pkg::OFS_IRQ_ENABLE,
    ssi_pkg::OFS_IRQ_DISABLE, ssi_pkg::OFS_IRQ_MASK, 8'h00, 8'h3C, 8'h50,
    8'hFF};

  always #5 i_clock = ~i_clock;

  ssi_datapath_model u_far (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_drive(drive),
    .i_step(step),
    .i_load(load),
    .i_counts(counts),
    .o_events(ev)
  );

  ssi_status_irq dut (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_addr(i_addr),
    .i_wr_data(i_wr_data),
    .i_wr_en(i_wr_en),
    .i_rd_en(i_rd_en),
    .i_events(ev),
    .o_rd_data(o_rd_data),
    .o_irq(o_irq)
  );

  // ****************************************************************
  // Reference model
  // ****************************************************************
  logic [11:0] fl_q, mk_q;
  logic [1:0] en_q;
  logic txz_q, rxz_q, irq_exp;
  logic [31:0] rd_exp;
  wire st_rd = i_rd_en && i_addr == ssi_pkg::OFS_STATUS;
  // Expected read word of one address, from the model's flags and mask.
  function automatic logic [31:0] exp_read(input logic [7:0] a,
      input logic [11:0] fl, input logic [11:0] mk, input logic [1:0] en);
    if (a == ssi_pkg::OFS_STATUS) return {14'h0000, en, 4'h0, fl};
    if (a == ssi_pkg::OFS_IRQ_MASK) return {20'h00000, mk};
    return 32'h0000_0000;
  endfunction
  // Next flags, bit 11 first; a set in the clearing cycle wins.
  wire [11:0] fl_d = {
    ev.rx_sync_event | fl_q[11] & !st_rd,
    ev.tx_sync_event | fl_q[10] & !st_rd,
    ev.compare_one_hit | fl_q[9] & !st_rd,
    ev.compare_zero_hit | fl_q[8] & !st_rd,
    ev.rx_dma_count_zero & ev.rx_dma_next_count_zero,
    ev.rx_dma_count_zero & !rxz_q | fl_q[6] & !ev.rx_count_write,
    ev.rx_holding_load & fl_q[4] | fl_q[5] & !st_rd,
    ev.rx_holding_load | fl_q[4] & !ev.rx_holding_read,
    ev.tx_dma_count_zero & ev.tx_dma_next_count_zero,
    ev.tx_dma_count_zero & !txz_q | fl_q[2] & !ev.tx_count_write,
    ev.tx_holding_empty & ev.tx_shift_idle,
    ev.tx_holding_empty};

  // Updated on the design's edge, so both see the same pre-edge inputs.
  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      {fl_q, mk_q, en_q, txz_q, rxz_q, irq_exp} <= 29'h0000_0000;
      rd_exp <= 32'h0000_0000;
    end else begin
      fl_q <= fl_d;
      en_q <= {ev.rx_enabled, ev.tx_enabled};
      {txz_q, rxz_q} <= {ev.tx_dma_count_zero, ev.rx_dma_count_zero};
      if (i_wr_en && i_addr == ssi_pkg::OFS_IRQ_ENABLE)
        mk_q <= mk_q | i_wr_data[11:0];
      else if (i_wr_en && i_addr == ssi_pkg::OFS_IRQ_DISABLE)
        mk_q <= mk_q & ~i_wr_data[11:0];
      rd_exp <= i_rd_en ? exp_read(i_addr, fl_q, mk_q, en_q) :
        32'h0000_0000;
      irq_exp <= |(fl_q & mk_q);
    end
  end

  // ****************************************************************
  // Checking and closing
  // ****************************************************************
  task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test;
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Outputs are settled mid-cycle; read data must be zero outside reads.
  always @(negedge i_clock) begin
    if (armed) begin
      check("tx", o_rd_data & 32'hF, rd_exp & 32'hF);
      check("rx", o_rd_data & 32'hF0, rd_exp & 32'hF0);
      check("evt", o_rd_data & 32'hF00, rd_exp & 32'hF00);
      check("en", o_rd_data & 32'h3_0000, rd_exp & 32'h3_0000);
      check("read word", o_rd_data, rd_exp);
      check("interrupt", 32'(o_irq), 32'(irq_exp));
    end
  end

  // A hang is cut short well beyond the planned run length.
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      end_of_test();
    end
  end

  // ****************************************************************
  // Stimulus
  // ****************************************************************
  // One bus cycle; datapath events and counter traffic are redrawn too.
  task automatic bus(input logic we, input logic re, input logic [7:0] a,
      input logic [31:0] d);
    logic [31:0] t;
    @(posedge i_clock);
    t = $random(seed);
    i_wr_en <= we;
    i_rd_en <= re;
    i_addr <= a;
    i_wr_data <= d;
    drive <= 16'($random(seed) & $random(seed));
    step <= t[0];
    load <= (t[5:3] == 3'h0) ? t[7:6] : 2'h0;
    counts <= t[15:8];
  endtask

  task automatic rand_ops(input int n);
    logic [31:0] r;
    repeat (n) begin
      r = $random(seed);
      case (r[2:0])
        3'h1: bus(1'b1, 1'b0, ssi_pkg::OFS_IRQ_ENABLE, $random(seed));
        3'h2: bus(1'b1, 1'b0, ssi_pkg::OFS_IRQ_DISABLE, $random(seed));
        3'h3: bus(1'b0, 1'b1, ssi_pkg::OFS_STATUS, 32'h0000_0000);
        3'h4: bus(1'b0, 1'b1, ssi_pkg::OFS_IRQ_MASK, 32'h0000_0000);
        3'h5: bus(1'b1, 1'b0, addrs[r[5:3]], $random(seed));
        3'h6: bus(1'b0, 1'b1, addrs[r[5:3]], 32'h0000_0000);
        default: bus(1'b0, 1'b0, 8'h00, 32'h0000_0000);
      endcase
    end
  endtask

  initial begin
    repeat (5) @(posedge i_clock);
    i_rst_n <= 1'b1;
    armed = 1'b1;
    // Corners: mask after reset, no-effect zeros, refused places.
    bus(1'b0, 1'b1, ssi_pkg::OFS_IRQ_MASK, 32'h0000_0000);
    bus(1'b1, 1'b0, ssi_pkg::OFS_IRQ_ENABLE, 32'hFFFF_FFFF);
    bus(1'b0, 1'b1, ssi_pkg::OFS_IRQ_MASK, 32'h0000_0000);
    bus(1'b1, 1'b0, ssi_pkg::OFS_IRQ_DISABLE, 32'h0000_0000);
    bus(1'b1, 1'b0, ssi_pkg::OFS_IRQ_DISABLE, 32'h0000_0555);
    bus(1'b1, 1'b0, ssi_pkg::OFS_STATUS, 32'hFFFF_FFFF);
    bus(1'b1, 1'b0, ssi_pkg::OFS_IRQ_MASK, 32'hFFFF_FFFF);
    bus(1'b0, 1'b1, ssi_pkg::OFS_IRQ_MASK, 32'h0000_0000);
    bus(1'b0, 1'b1, ssi_pkg::OFS_IRQ_ENABLE, 32'h0000_0000);
    bus(1'b0, 1'b1, ssi_pkg::OFS_IRQ_DISABLE, 32'h0000_0000);
    bus(1'b0, 1'b1, 8'h50, 32'h0000_0000);
    bus(1'b0, 1'b1, ssi_pkg::OFS_STATUS, 32'h0000_0000);
    bus(1'b0, 1'b1, ssi_pkg::OFS_STATUS, 32'h0000_0000);
    rand_ops(3000);
    // A reset in mid-run must drop the whole mask again.
    i_rst_n <= 1'b0;
    repeat (2) bus(1'b0, 1'b0, 8'h00, 32'h0000_0000);
    i_rst_n <= 1'b1;
    bus(1'b0, 1'b1, ssi_pkg::OFS_IRQ_MASK, 32'h0000_0000);
    rand_ops(1500);
    repeat (2) bus(1'b0, 1'b0, 8'h00, 32'h0000_0000);
    end_of_test();
  end
endmodule
